/* File: design/acc_clock_control.sv */
// Purpose: clock control: divider straps, clock-out select, start pulse select, clock gates
// Assumes: CLK_SYS_I is the master clock from the crystal input; all inputs synchronous to it
// Notes: the core-clock multiplier is analog; here a base-rate tick stands for the 64x clock
//
// How it works
// - ratio straps 000..100 pick divide by 1,2,4,6,8 to get 64x base clock.
// - normal rate gives core clock of 3584 cycles per sample by default.
// - internal dual rate is twice normal, quad rate four times normal.
// - clock-out straps pick off, oscillator, 256x or 512x normal rate.
// - each start pulse begins one core pass and sets its sample rate.
// - start pulse may come from three internal rates or 12 input frame clocks.
// - start pulse may come from any of 12 output frame clocks.
// - start pulse may come from the receiver's recovered frame clock.
// - writing rate select changes start pulse source and core speed.
// - clock enable bit 0 stops a subsystem clock, 1 supplies it.
// - bits 8, 7, 6 gate auxiliary converters, transmitter, receiver.
// - bit 5 gates the processing core clock.
// - bit 4 gates upper four rate converters, bit 3 the lower four.
// - bits 2, 1, 0 gate serial outputs, serial inputs, routing matrix.
// - five-bit select codes internal rates, input pairs, output pairs, receiver.
// - codes 11100 to 11111 give no start pulse, core stays idle.
`timescale 1ns/1ps
`include "adc_clkctl_defines.svh"

module acc_clock_control #(
  parameter int NUM_PAIRS = `ACC_NUM_PAIRS,
  parameter int BASE_MULT = `ACC_BASE_MULT
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic CLK_EN_I,
  input wire logic [2:0] RATIO_SELECT_I,
  input wire logic [1:0] CLOCK_OUT_SELECT_I,
  input wire logic [NUM_PAIRS-1:0] IN_FRAME_I,
  input wire logic [NUM_PAIRS-1:0] OUT_FRAME_I,
  input wire logic RX_FRAME_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic BASE_TICK_O,
  output logic CLOCK_OUT_PIN_O,
  output logic CORE_START_O,
  output logic [`ACC_CLK_EN_W-1:0] CLK_GATE_O,
  output logic [2:0] DIVIDER_O
);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and divider decode

  acc_pkg::acc_straps_s straps_reg;
  logic straps_taken_reg;
  logic [3:0] ratio_div;
  logic [`ACC_RATE_SEL_W-1:0] rate_sel_reg;
  acc_pkg::acc_clk_en_s clk_en_reg;

  function automatic logic [3:0] ratio_to_div(input logic [2:0] code);
    case (code)
      3'h0: ratio_to_div = 4'h1;
      3'h1: ratio_to_div = 4'h2;
      3'h2: ratio_to_div = 4'h4;
      3'h3: ratio_to_div = 4'h6;
      3'h4: ratio_to_div = 4'h8;
      default: ratio_to_div = 4'h1;
    endcase
  endfunction

  // capture happens one clock after release, never from the reset branch itself;
  // strap moves are only legal in reset, so later changes are ignored
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      straps_taken_reg <= 1'b0;
      straps_reg <= '0;
    end else if (CLK_EN_I && !straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      straps_reg.ratio <= RATIO_SELECT_I;
      straps_reg.clock_out_pin <= CLOCK_OUT_SELECT_I;
    end
  end

  assign ratio_div = ratio_to_div(straps_reg.ratio);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      DIVIDER_O <= 3'h0;
    end else if (CLK_EN_I) begin
      DIVIDER_O <= straps_reg.ratio;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 64x base-rate tick and internal sample-rate ticks

  logic [3:0] div_cnt_reg;
  logic base_tick;
  logic [5:0] base_cnt_reg;
  logic [1:0] half_cnt_reg;

  assign base_tick = straps_taken_reg && (div_cnt_reg == ratio_div - 4'h1);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      div_cnt_reg <= 4'h0;
    end else if (CLK_EN_I && straps_taken_reg) begin
      div_cnt_reg <= base_tick ? 4'h0 : div_cnt_reg + 4'h1;
    end
  end

  // 64 base ticks per normal sample; quad every 16, dual every 32
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      base_cnt_reg <= 6'h00;
    end else if (CLK_EN_I && base_tick) begin
      base_cnt_reg <= base_cnt_reg + 6'h01;
    end
  end

  // 256x/512x normal rate are 4x/8x base; emulated from a free-running system-clock counter
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      half_cnt_reg <= 2'h0;
    end else if (CLK_EN_I) begin
      half_cnt_reg <= half_cnt_reg + 2'h1;
    end
  end

  logic fs_normal;
  logic fs_dual;
  logic fs_quad;
  assign fs_normal = base_tick && (base_cnt_reg == 6'h3F);
  assign fs_dual = base_tick && (base_cnt_reg[4:0] == 5'h1F);
  assign fs_quad = base_tick && (base_cnt_reg[3:0] == 4'hF);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      BASE_TICK_O <= 1'b0;
    end else if (CLK_EN_I) begin
      BASE_TICK_O <= base_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock-out pin

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      CLOCK_OUT_PIN_O <= 1'b0;
    end else if (CLK_EN_I) begin
      case (acc_pkg::acc_clock_out_pin_e'(straps_reg.clock_out_pin))
        acc_pkg::ACC_CO_OFF: CLOCK_OUT_PIN_O <= 1'b0;
        acc_pkg::ACC_CO_OSC: CLOCK_OUT_PIN_O <= ~CLOCK_OUT_PIN_O;
        acc_pkg::ACC_CO_256: CLOCK_OUT_PIN_O <= half_cnt_reg[1];
        acc_pkg::ACC_CO_512: CLOCK_OUT_PIN_O <= half_cnt_reg[0];
        default: CLOCK_OUT_PIN_O <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start pulse select

  logic [NUM_PAIRS-1:0] in_prev_reg;
  logic [NUM_PAIRS-1:0] out_prev_reg;
  logic rx_prev_reg;
  logic [NUM_PAIRS-1:0] in_rise;
  logic [NUM_PAIRS-1:0] out_rise;
  logic start_sel;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      in_prev_reg <= '0;
      out_prev_reg <= '0;
      rx_prev_reg <= 1'b0;
    end else if (CLK_EN_I) begin
      in_prev_reg <= IN_FRAME_I;
      out_prev_reg <= OUT_FRAME_I;
      rx_prev_reg <= RX_FRAME_I;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_edge
      assign in_rise[g] = IN_FRAME_I[g] & ~in_prev_reg[g];
      assign out_rise[g] = OUT_FRAME_I[g] & ~out_prev_reg[g];
    end
  endgenerate

  always_comb begin
    logic [4:0] idx;
    idx = 5'h00;
    start_sel = 1'b0;
    if (rate_sel_reg == `ACC_SEL_NORMAL) begin
      start_sel = fs_normal;
    end else if (rate_sel_reg == `ACC_SEL_DUAL) begin
      start_sel = fs_dual;
    end else if (rate_sel_reg == `ACC_SEL_QUAD) begin
      start_sel = fs_quad;
    end else if (rate_sel_reg < `ACC_SEL_OUT0) begin
      idx = rate_sel_reg - `ACC_SEL_IN0;
      start_sel = in_rise[idx[3:0]];
    end else if (rate_sel_reg < `ACC_SEL_RX) begin
      idx = rate_sel_reg - `ACC_SEL_OUT0;
      start_sel = out_rise[idx[3:0]];
    end else if (rate_sel_reg == `ACC_SEL_RX) begin
      start_sel = RX_FRAME_I & ~rx_prev_reg;
    end else begin
      start_sel = 1'b0;
    end
  end

  // the core gets no start pulse while its own clock is gated off
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      CORE_START_O <= 1'b0;
    end else if (CLK_EN_I) begin
      CORE_START_O <= start_sel & clk_en_reg.core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file: zero wait states, pslverr on unmapped addresses

  logic apb_access;
  logic hit_rate;
  logic hit_en;
  assign apb_access = PSEL_I && PENABLE_I && CLK_EN_I;
  assign hit_rate = (PADDR_I == `ACC_RATE_SEL_OFFSET);
  assign hit_en = (PADDR_I == `ACC_CLK_EN_OFFSET);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      rate_sel_reg <= `ACC_RATE_SEL_RESET;
    end else if (apb_access && PWRITE_I && hit_rate) begin
      rate_sel_reg <= PWDATA_I[`ACC_RATE_SEL_W-1:0];
    end
  end

  // writing this first after power-up is software's duty; the block imposes no order
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      clk_en_reg <= `ACC_CLK_EN_RESET;
    end else if (apb_access && PWRITE_I && hit_en) begin
      clk_en_reg <= PWDATA_I[`ACC_CLK_EN_W-1:0];
    end
  end

  // ready is combinational-free: registered as the setup phase is seen
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (CLK_EN_I) begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !hit_rate && !hit_en;
      if (PSEL_I && !PENABLE_I && !PWRITE_I && hit_rate) begin
        PRDATA_O <= {27'h0, rate_sel_reg};
      end else if (PSEL_I && !PENABLE_I && !PWRITE_I && hit_en) begin
        PRDATA_O <= {23'h0, clk_en_reg};
      end else begin
        PRDATA_O <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // subsystem clock gates

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      CLK_GATE_O <= `ACC_CLK_EN_RESET;
    end else if (CLK_EN_I) begin
      CLK_GATE_O[`ACC_EN_AUX] <= clk_en_reg.aux;
      CLK_GATE_O[`ACC_EN_TX] <= clk_en_reg.tx;
      CLK_GATE_O[`ACC_EN_RX] <= clk_en_reg.rx;
      CLK_GATE_O[`ACC_EN_CORE] <= clk_en_reg.core;
      CLK_GATE_O[`ACC_EN_SRC_HI] <= clk_en_reg.src_hi;
      CLK_GATE_O[`ACC_EN_SRC_LO] <= clk_en_reg.src_lo;
      CLK_GATE_O[`ACC_EN_SOUT] <= clk_en_reg.sout;
      CLK_GATE_O[`ACC_EN_SIN] <= clk_en_reg.sin;
      CLK_GATE_O[`ACC_EN_ROUTE] <= clk_en_reg.route;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  gate_follow_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    CLK_EN_I |=> CLK_GATE_O == $past(clk_en_reg))
    else $error("clock gate does not follow enable register");

  start_gated_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    CORE_START_O |-> $past(clk_en_reg.core))
    else $error("start pulse while core clock is off");

  no_pulse_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (rate_sel_reg > `ACC_SEL_RX) |-> !start_sel)
    else $error("start pulse from a disabling code");

  normal_rate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (fs_normal && CLK_EN_I) |=> !(fs_normal && CLK_EN_I) [*8])
    else $error("normal rate pulses too close");

  // a frozen tick must not look like a fresh pulse once the enable returns
  freeze_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !CLK_EN_I |=> $stable(CLOCK_OUT_PIN_O) && $stable(BASE_TICK_O))
    else $error("outputs moved while clock enable low");

  dual_rate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    fs_normal |-> fs_dual && fs_quad)
    else $error("internal rates not aligned");

  divider_map_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (straps_reg.ratio == 3'h3 && straps_taken_reg) |-> ratio_div == 4'h6)
    else $error("divide ratio decode wrong");

  strap_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $past(straps_taken_reg) |-> $stable(straps_reg))
    else $error("straps changed after capture");

  reserved_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    PRDATA_O[31:9] == 23'h0)
    else $error("reserved bits read nonzero");

  rate_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (apb_access && PWRITE_I && hit_rate) |=> rate_sel_reg == $past(PWDATA_I[4:0]))
    else $error("rate select write lost");

  off_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (straps_taken_reg && straps_reg.clock_out_pin == 2'h0 && CLK_EN_I) |=> !CLOCK_OUT_PIN_O)
    else $error("clock-out active while disabled");

endmodule

/* File: design/adc_clkctl_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts for the clock control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: register offsets are byte addresses
`ifndef ADC_CLKCTL_DEFINES_SVH
`define ADC_CLKCTL_DEFINES_SVH

`define ACC_RATE_SEL_OFFSET 16'hE220
`define ACC_CLK_EN_OFFSET 16'hE280
`define ACC_RATE_SEL_RESET 5'h00
`define ACC_CLK_EN_RESET 9'h000
`define ACC_RATE_SEL_W 5
`define ACC_CLK_EN_W 9
`define ACC_EN_ROUTE 0
`define ACC_EN_SIN 1
`define ACC_EN_SOUT 2
`define ACC_EN_SRC_LO 3
`define ACC_EN_SRC_HI 4
`define ACC_EN_CORE 5
`define ACC_EN_RX 6
`define ACC_EN_TX 7
`define ACC_EN_AUX 8
`define ACC_SEL_NORMAL 5'h00
`define ACC_SEL_DUAL 5'h01
`define ACC_SEL_QUAD 5'h02
`define ACC_SEL_IN0 5'h03
`define ACC_SEL_OUT0 5'h0F
`define ACC_SEL_RX 5'h1B
`define ACC_BASE_MULT 56
`define ACC_NORMAL_IPS 3584
`define ACC_DUAL_IPS 1792
`define ACC_QUAD_IPS 896
`define ACC_NUM_PAIRS 12

`endif

/* File: design/acc_pkg.sv */
// Purpose: types for the clock control block
// Assumes: nothing beyond the defines header
// Notes: structs group the strap pins and the gated clock enables
package acc_pkg;

  typedef struct packed {
    logic [2:0] ratio;
    logic [1:0] clock_out_pin;
  } acc_straps_s;

  typedef struct packed {
    logic aux;
    logic tx;
    logic rx;
    logic core;
    logic src_hi;
    logic src_lo;
    logic sout;
    logic sin;
    logic route;
  } acc_clk_en_s;

  typedef enum logic [1:0] {
    ACC_CO_OFF,
    ACC_CO_OSC,
    ACC_CO_256,
    ACC_CO_512
  } acc_clock_out_pin_e;

endpackage

/* File: tb/acc_far_side.sv */
// Purpose: far-side model: pin straps and frame clocks seen by the clock control block
// Assumes: the bench asks for one frame by raising one request bit for a couple of cycles
// Notes: straps only follow a request while reset is low, like a real board strap change
`timescale 1ns/1ps

module acc_far_side (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire acc_pkg::acc_straps_s strap_req_i,
  input wire logic [24:0] frame_req_i,
  output acc_pkg::acc_straps_s straps_o,
  output logic [11:0] in_frame_o,
  output logic [11:0] out_frame_o,
  output logic rx_frame_o
);
  // a strap change outside reset would be a board fault, so it is never passed on
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      straps_o <= strap_req_i;
    end
  end

  // frame clocks are plain levels; low between frames
  always_ff @(posedge clk_i) begin
    {rx_frame_o, out_frame_o, in_frame_o} <= frame_req_i;
  end
endmodule

/* File: tb/test_acc_clock_control.sv */
// Purpose: self-checking bench for the clock control block
// Assumes: clock enable high except in one freeze check; zero-wait apb slave
// Notes: outputs are sampled at the rising edge, before that edge's updates land
`timescale 1ns/1ps
`include "adc_clkctl_defines.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t got %0h expected %0h", $time, got, exp); end end

module test_acc_clock_control;
  logic clk;
  logic rst_b;
  logic clk_en;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic base_tick;
  logic clock_out;
  logic core_start;
  logic [8:0] clk_gate;
  logic [2:0] divider;
  acc_pkg::acc_straps_s strap_req;
  acc_pkg::acc_straps_s straps;
  logic [24:0] frame_req;
  logic [11:0] in_frame;
  logic [11:0] out_frame;
  logic rx_frame;
  int error_cnt;
  int samples_checked;
  int cycles;

  acc_clock_control u_acc_clock_control (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CLK_EN_I(clk_en),
    .RATIO_SELECT_I(straps.ratio), .CLOCK_OUT_SELECT_I(straps.clock_out_pin),
    .IN_FRAME_I(in_frame), .OUT_FRAME_I(out_frame), .RX_FRAME_I(rx_frame),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .BASE_TICK_O(base_tick), .CLOCK_OUT_PIN_O(clock_out), .CORE_START_O(core_start),
    .CLK_GATE_O(clk_gate), .DIVIDER_O(divider));

  acc_far_side u_acc_far_side (.clk_i(clk), .rst_b_i(rst_b), .strap_req_i(strap_req),
    .frame_req_i(frame_req), .straps_o(straps), .in_frame_o(in_frame),
    .out_frame_o(out_frame), .rx_frame_o(rx_frame));

  always #50 clk = ~clk;

  // a hang anywhere ends here; the whole run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(pready, 1'b1)
  endtask

  task automatic wreg(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, wd, rd, e);
    `CHK(e, 1'b0)
  endtask

  task automatic rreg(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    `CHK(e, 1'b0)
    `CHK(rd, exp)
  endtask

  task automatic reset_dut(input logic [2:0] r, input logic [1:0] co);
    rst_b <= 1'b0;
    strap_req <= {r, co};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // capture on the first edge, divider output on the second, seen on the third
    repeat (3) @(posedge clk);
  endtask

  // counts clock-out changes over 16 edges
  task automatic toggles(output int t);
    logic prev;
    t = 0;
    @(posedge clk);
    prev = clock_out;
    repeat (16) begin
      @(posedge clk);
      if (clock_out !== prev) begin
        t++;
      end
      prev = clock_out;
    end
  endtask

  function automatic logic pick(input logic which);
    return which ? core_start : base_tick;
  endfunction

  // cycles from one pulse to the next
  task automatic gap(input logic which, output int n);
    int w;
    w = 0;
    n = 0;
    while (pick(which) !== 1'b1 && w < 400) begin
      @(posedge clk);
      w++;
    end
    do begin
      @(posedge clk);
      n++;
    end while (pick(which) !== 1'b1 && n < 400);
  endtask

  // optionally raises one frame line, then counts start pulses in the window
  task automatic count(input int idx, input int len, output int n);
    n = 0;
    if (idx >= 0) begin
      frame_req <= 25'h1 << idx;
    end
    for (int k = 0; k < len; k++) begin
      @(posedge clk);
      if (k == 2) begin
        frame_req <= '0;
      end
      if (core_start === 1'b1) begin
        n++;
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic strap_modes;
    int n;
    int t;
    int divs[5] = '{1, 2, 4, 6, 8};
    int togs[5] = '{0, 16, 8, 16, 0};
    for (int i = 0; i < 5; i++) begin
      reset_dut(i[2:0], i[1:0]);
      `CHK(divider, i[2:0])
      gap(1'b0, n);
      `CHK(n, divs[i])
      toggles(t);
      `CHK(t, togs[i])
    end
    // a low clock enable freezes the pin even in oscillator mode
    reset_dut(3'h0, 2'h1);
    clk_en <= 1'b0;
    toggles(t);
    `CHK(t, 0)
    clk_en <= 1'b1;
    toggles(t);
    `CHK(t, 16)
  endtask

  task automatic reg_access;
    logic [31:0] rd;
    logic e;
    reset_dut(3'h0, 2'h0);
    rreg(`ACC_CLK_EN_OFFSET, 32'h0000_0000);
    rreg(`ACC_RATE_SEL_OFFSET, 32'h0000_0000);
    wreg(`ACC_RATE_SEL_OFFSET, 32'hFFFF_FFFF);
    rreg(`ACC_RATE_SEL_OFFSET, 32'h0000_001F);
    wreg(`ACC_CLK_EN_OFFSET, 32'hFFFF_FFFF);
    rreg(`ACC_CLK_EN_OFFSET, 32'h0000_01FF);
    apb(1'b1, 16'hE224, 32'hFFFF_FFFF, rd, e);
    `CHK(e, 1'b1)
    apb(1'b0, 16'hE224, 32'h0000_0000, rd, e);
    `CHK(rd, 32'h0000_0000)
    for (int b = 0; b < 9; b++) begin
      wreg(`ACC_CLK_EN_OFFSET, 32'h1 << b);
      repeat (2) @(posedge clk);
      `CHK(clk_gate, 9'h001 << b)
    end
  endtask

  task automatic internal_rates;
    int n;
    int per[3] = '{64, 32, 16};
    reset_dut(3'h0, 2'h0);
    wreg(`ACC_CLK_EN_OFFSET, 32'h0000_01FF);
    for (int c = 0; c < 3; c++) begin
      wreg(`ACC_RATE_SEL_OFFSET, c);
      gap(1'b1, n);
      gap(1'b1, n);
      `CHK(n, per[c])
    end
    for (int c = 28; c < 32; c++) begin
      wreg(`ACC_RATE_SEL_OFFSET, c);
      count(-1, 150, n);
      `CHK(n, 0)
    end
    // core gate off must hold the core idle even on the normal rate
    wreg(`ACC_CLK_EN_OFFSET, 32'h0000_01DF);
    wreg(`ACC_RATE_SEL_OFFSET, 32'h0000_0000);
    count(-1, 150, n);
    `CHK(n, 0)
  endtask

  task automatic frame_sources;
    int n;
    wreg(`ACC_CLK_EN_OFFSET, 32'h0000_01FF);
    for (int c = 3; c < 28; c++) begin
      wreg(`ACC_RATE_SEL_OFFSET, c);
      count((c - 2) % 25, 10, n);
      `CHK(n, 0)
      count(c - 3, 10, n);
      `CHK(n, 1)
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    strap_req = '0;
    frame_req = '0;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    strap_modes();
    reg_access();
    internal_rates();
    frame_sources();
    test_done();
  end
endmodule
